// *** ovh_insert_port.sv ***
// Transmit overhead insert port of one mapper channel, with its synchroniser.
// Assumes ovh_clock runs at twice the port clock and that the partner works
// on the port clock driven out here; configuration comes from the core clock.
`include "ovh_port_regs.svh"

module ovh_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Level in and filtered level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // A bit changes only once the second and third stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= q_nxt;
    end
  end

endmodule

// Notes on behaviour
// - DS3/E3: enable high inserts serial overhead bits
// - STS-1: sample data on port clock falling edge
// - STS-1: configured overrides take external bytes in offered slots despite enable (TOH override has no effect in POH only)
// - DS3/E3: one-period frame pulse at first bit
// - POH only: frame pulse when J1 expected
// - TOH and POH: pulses at A1 and J1
// - Strobe low means A1, high means J1
// - STS-1: strobe pulses at each offered byte except A1, else low
// - POH only: frame pulse lasts eight periods
module ovh_insert_port (
  // Core clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Configuration, core clock domain
  input  wire logic [1:0] cfg_mode,
  input  wire logic [1:0] cfg_src_override,
  // Captured overhead bytes, core clock domain
  output logic      [7:0] ovh_byte_out,
  output logic            ovh_byte_ext,
  output logic            ovh_byte_valid,
  // Overhead clock domain towards the frame generator
  input  wire logic       ovh_clock,
  input  wire logic       int_ovh_bit,
  output logic            tx_ovh_bit,
  output logic            tx_ovh_valid,
  output logic            tx_ovh_frame_start,
  // Partner port
  input  wire logic       ovh_insert_enable,
  input  wire logic       ovh_serial_data_in,
  output logic            ovh_port_clock_out,
  output logic            ovh_frame_pulse,
  output logic            ovh_byte_slot_strobe
);

  // Overhead clock domain state
  logic [3:0]                cfg_s;
  ovh_pkg::ovh_mode_type     mode_s;
  logic                      ph_r;
  logic [12:0]               slot_r;
  logic [12:0]               slot_nxt;
  logic [12:0]               frame_len;
  logic [7:0]                shift_r;
  logic [7:0]                hold_r;
  logic                      hold_ext_r;
  logic                      ext_acc_r;
  logic                      tgl_r;
  logic [4:0]                fr_cnt_r;

  // Core clock domain state
  logic                      tgl_s;
  logic                      tgl_seen_r;

  // Decode wires
  wire                       is_poh;
  wire                       is_dual;
  wire                       is_sts;
  wire                       slot_last;
  wire                       n_poh;
  wire                       n_first;
  wire                       n_offered;
  wire                       n_a1;
  wire                       n_j1;
  wire                       frame_nxt;
  wire                       strobe_nxt;
  wire                       cur_toh;
  wire                       cur_offered;
  wire                       ovr_cur;
  wire                       take;
  wire                       bit_nxt;
  wire                       byte_end;
  wire                       tgl_new;

  // Configuration crosses into the overhead clock domain
  ovh_sync3 #(.W(4)) u_cfg_sync (
    .clock (ovh_clock),
    .rst_n (rst_n),
    .d     ({cfg_src_override, cfg_mode}),
    .q     (cfg_s)
  );

  assign mode_s  = ovh_pkg::ovh_mode_type'(cfg_s[1:0]);
  assign is_poh  = (mode_s == ovh_pkg::MODE_STS_POH);
  assign is_dual = (mode_s == ovh_pkg::MODE_STS_TOH_POH);
  assign is_sts  = is_poh | is_dual;

  // Slot counter over one frame of port clock periods
  assign frame_len = is_sts ? `OVH_STS_FRAME_SLOTS : `OVH_DS3_FRAME_SLOTS;
  assign slot_last = (slot_r >= (frame_len - `OVH_SLOT_ONE));
  assign slot_nxt  = slot_last ? `OVH_SLOT_ZERO : (slot_r + `OVH_SLOT_ONE);

  // Look-ahead decode: outputs announce the slot about to be sampled
  assign n_poh     = (slot_nxt >= `OVH_POH_START);
  assign n_first   = (slot_nxt[2:0] == `OVH_BYTE_FIRST_BIT);
  assign n_offered = is_dual | n_poh;
  assign n_a1      = (slot_nxt == `OVH_SLOT_ZERO);
  assign n_j1      = n_poh & (slot_nxt < (`OVH_POH_START + `OVH_BYTE_SLOTS));

  assign frame_nxt = is_dual ? (n_a1 | (slot_nxt == `OVH_POH_START)) :
                     is_poh  ? n_j1 :
                               n_a1;

  // A1 keeps the strobe low so the partner can tell it from J1
  assign strobe_nxt = is_sts & n_offered & n_first & ~n_a1;

  // Current slot: source selection for the bit sampled now
  assign cur_toh     = (slot_r < `OVH_POH_START);
  assign cur_offered = ~is_sts | is_dual | ~cur_toh;
  assign ovr_cur     = is_sts & (cur_toh ? cfg_s[`OVH_OVR_TOH_BIT] : cfg_s[`OVH_OVR_POH_BIT]);
  assign take        = cur_offered & (ovh_insert_enable | ovr_cur);
  assign bit_nxt     = take ? ovh_serial_data_in : int_ovh_bit;
  assign byte_end    = (slot_r[2:0] == `OVH_BYTE_LAST_BIT);

  // Port clock and slot timing; ph_r high means the port clock falls next
  always_ff @(posedge ovh_clock or negedge rst_n) begin
    if (!rst_n) begin
      ph_r   <= 1'h0;
      slot_r <= 13'h0000;
    end else begin
      ph_r <= ~ph_r;
      if (ph_r) begin
        slot_r <= slot_nxt;
      end
    end
  end

  // Port outputs change on the port clock falling edge
  always_ff @(posedge ovh_clock or negedge rst_n) begin
    if (!rst_n) begin
      ovh_port_clock_out   <= 1'h0;
      ovh_frame_pulse      <= 1'h0;
      ovh_byte_slot_strobe <= 1'h0;
    end else begin
      ovh_port_clock_out <= ~ph_r;
      if (ph_r) begin
        ovh_frame_pulse      <= frame_nxt;
        ovh_byte_slot_strobe <= strobe_nxt;
      end
    end
  end

  // One bit per port period towards the frame generator
  always_ff @(posedge ovh_clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_ovh_bit         <= 1'h0;
      tx_ovh_valid       <= 1'h0;
      tx_ovh_frame_start <= 1'h0;
      shift_r            <= 8'h00;
    end else begin
      tx_ovh_valid       <= ph_r;
      tx_ovh_frame_start <= ph_r & (slot_r == `OVH_SLOT_ZERO);
      if (ph_r) begin
        tx_ovh_bit <= bit_nxt;
        shift_r    <= {shift_r[6:0], bit_nxt};
      end
    end
  end

  // Byte hand-off: data held steady while a toggle crosses
  always_ff @(posedge ovh_clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_r     <= 8'h00;
      hold_ext_r <= 1'h0;
      ext_acc_r  <= 1'h0;
      tgl_r      <= 1'h0;
    end else if (ph_r) begin
      if (byte_end) begin
        hold_r     <= {shift_r[6:0], bit_nxt};
        hold_ext_r <= ext_acc_r | take;
        ext_acc_r  <= 1'h0;
        tgl_r      <= ~tgl_r;
      end else begin
        ext_acc_r <= ext_acc_r | take;
      end
    end
  end

  // Framing pulse width in link clock cycles, read by the checks
  always_ff @(posedge ovh_clock or negedge rst_n) begin
    if (!rst_n) begin
      fr_cnt_r <= 5'h00;
    end else if (ovh_frame_pulse) begin
      fr_cnt_r <= fr_cnt_r + 5'h01;
    end else begin
      fr_cnt_r <= 5'h00;
    end
  end

  // Byte toggle crosses into the core clock domain
  ovh_sync3 #(.W(1)) u_tgl_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (tgl_r),
    .q     (tgl_s)
  );

  assign tgl_new = (tgl_s != tgl_seen_r);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tgl_seen_r     <= 1'h0;
      ovh_byte_out   <= 8'h00;
      ovh_byte_ext   <= 1'h0;
      ovh_byte_valid <= 1'h0;
    end else begin
      tgl_seen_r     <= tgl_s;
      ovh_byte_valid <= tgl_new;
      if (tgl_new) begin
        ovh_byte_out <= hold_r;
        ovh_byte_ext <= hold_ext_r;
      end
    end
  end

  // Checks

  chk_ds3_frame_width: assert property (
    @(posedge ovh_clock) disable iff (!rst_n)
    ($rose(ovh_frame_pulse) && !is_sts) |=> ovh_frame_pulse ##1 !ovh_frame_pulse
  ) else $error("DS3/E3 framing pulse not one port period");

  chk_poh_frame_len: assert property (
    @(posedge ovh_clock) disable iff (!rst_n)
    ($fell(ovh_frame_pulse) && is_poh) |-> (fr_cnt_r == `OVH_FRAME_HIGH_CYCLES)
  ) else $error("POH framing pulse not eight port periods");

  chk_frame_position: assert property (
    @(posedge ovh_clock) disable iff (!rst_n)
    ($rose(ovh_frame_pulse) && is_sts) |->
      (slot_r == `OVH_POH_START) || (is_dual && slot_r == `OVH_SLOT_ZERO)
  ) else $error("STS-1 framing pulse at wrong slot");

  chk_a1_strobe_low: assert property (
    @(posedge ovh_clock) disable iff (!rst_n)
    (ovh_frame_pulse && is_dual) |-> (ovh_byte_slot_strobe == (slot_r == `OVH_POH_START))
  ) else $error("Strobe does not tell A1 from J1");

  chk_strobe_pulse: assert property (
    @(posedge ovh_clock) disable iff (!rst_n)
    $rose(ovh_byte_slot_strobe) |-> is_sts ##1 ovh_byte_slot_strobe ##1 !ovh_byte_slot_strobe
  ) else $error("Byte strobe not a one-period pulse");

  chk_ext_data_taken: assert property (
    @(posedge ovh_clock) disable iff (!rst_n)
    (ph_r && cur_offered && ovh_insert_enable && ovh_port_clock_out) |=>
      (tx_ovh_bit == $past(ovh_serial_data_in)) && !ovh_port_clock_out
  ) else $error("External overhead bit not taken on falling edge");

  chk_internal_bit: assert property (
    @(posedge ovh_clock) disable iff (!rst_n)
    (ph_r && !ovh_insert_enable && !ovr_cur) |=> (tx_ovh_bit == $past(int_ovh_bit))
  ) else $error("Internal overhead bit not used");

  chk_byte_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    ovh_byte_valid |=> !ovh_byte_valid [*3]
  ) else $error("Byte valid pulse too long or too close");

endmodule

// *** ovh_port_regs.svh ***
// Timing and layout constants for the transmit overhead insert port.
// Assumes inclusion by its bare name from the port's design file.
`ifndef OVH_PORT_REGS_SVH
`define OVH_PORT_REGS_SVH

// Overhead slots per frame, one slot per port clock period
`define OVH_DS3_FRAME_SLOTS  13'h0038
`define OVH_STS_FRAME_SLOTS  13'h0120
// First slot of the path overhead bytes (J1)
`define OVH_POH_START        13'h00D8
// Slots in one overhead byte
`define OVH_BYTE_SLOTS       13'h0008
`define OVH_SLOT_ZERO        13'h0000
`define OVH_SLOT_ONE         13'h0001
// Bit position within a byte
`define OVH_BYTE_FIRST_BIT   3'h0
`define OVH_BYTE_LAST_BIT    3'h7
// Port clock cycles of the long framing pulse, counted in link clock cycles
`define OVH_FRAME_HIGH_CYCLES 5'h10
// Source override bit positions within the configuration word
`define OVH_OVR_POH_BIT      2
`define OVH_OVR_TOH_BIT      3

`endif

// *** ovh_pkg.sv ***
// Types shared by the transmit overhead insert port.
// Assumes nothing of its surroundings.
package ovh_pkg;

  typedef enum logic [1:0] {
    MODE_DS3E3       = 2'h0,
    MODE_STS_POH     = 2'h1,
    MODE_STS_TOH_POH = 2'h2
  } ovh_mode_type;

endpackage

// *** ovh_partner.sv ***
// Partner model: terminal equipment inserting overhead bytes.
// Assumes the port clock, framing pulse and strobe of the insert port.
module ovh_partner (
  // Device outputs
  input  wire logic       ovh_port_clock_out,
  input  wire logic       ovh_frame_pulse,
  input  wire logic       ovh_byte_slot_strobe,
  // Bench control
  input  wire logic       ins_on,
  input  wire logic [7:0] ins_byte,
  // Partner drives
  output logic            ovh_insert_enable,
  output logic            ovh_serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_r = 8'h00;
  logic [3:0] left_r = 4'h0;
  logic       fp_r = 1'b0;
  logic       en_r = 1'b0;
  logic       dat_r = 1'b0;
  assign ovh_insert_enable = en_r;
  assign ovh_serial_data_in = dat_r;
  // New byte at a strobe or a fresh frame pulse, next bit each rising edge
  always @(posedge ovh_port_clock_out) begin
    fp_r <= ovh_frame_pulse;
    if (ovh_byte_slot_strobe || (ovh_frame_pulse && !fp_r)) begin
      en_r <= ins_on;
      dat_r <= ins_byte[7];
      sh_r <= {ins_byte[6:0], 1'b0};
      left_r <= 4'h7;
    end else if (left_r != 4'h0) begin
      dat_r <= sh_r[7];
      sh_r <= {sh_r[6:0], 1'b0};
      left_r <= left_r - 4'h1;
    end else begin
      en_r <= 1'b0;
      dat_r <= ~dat_r;
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the transmit overhead insert port.
// Assumes the port's design files and the partner model.
`include "ovh_port_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0;
  logic       ovh_clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] cfg_mode = 2'h0;
  logic [1:0] cfg_src_override = 2'h0;
  logic       int_ovh_bit = 1'b0;
  logic       ins_on = 1'b0;
  logic [7:0] ovh_byte_out;
  logic       ovh_byte_ext;
  logic       ovh_byte_valid;
  logic       ovh_insert_enable;
  logic       ovh_serial_data_in;
  logic       ovh_port_clock_out;
  logic       ovh_frame_pulse;
  logic       ovh_byte_slot_strobe;
  logic       tx_ovh_bit;
  logic       tx_ovh_valid;
  logic       tx_ovh_frame_start;
  int         mismatches = 0;
  int         checks_done = 0;
  int         cyc = 0;

  always #20 clock = ~clock;
  always #24 ovh_clock = ~ovh_clock;

  ovh_insert_port dut (
    .clock(clock), .rst_n(rst_n), .cfg_mode(cfg_mode), .cfg_src_override(cfg_src_override),
    .ovh_byte_out(ovh_byte_out), .ovh_byte_ext(ovh_byte_ext), .ovh_byte_valid(ovh_byte_valid),
    .ovh_clock(ovh_clock), .int_ovh_bit(int_ovh_bit), .tx_ovh_bit(tx_ovh_bit), .tx_ovh_valid(tx_ovh_valid),
    .tx_ovh_frame_start(tx_ovh_frame_start), .ovh_insert_enable(ovh_insert_enable),
    .ovh_serial_data_in(ovh_serial_data_in), .ovh_port_clock_out(ovh_port_clock_out),
    .ovh_frame_pulse(ovh_frame_pulse), .ovh_byte_slot_strobe(ovh_byte_slot_strobe));

  ovh_partner far_end (
    .ovh_port_clock_out(ovh_port_clock_out), .ovh_frame_pulse(ovh_frame_pulse),
    .ovh_byte_slot_strobe(ovh_byte_slot_strobe), .ins_on(ins_on), .ins_byte(8'hA5),
    .ovh_insert_enable(ovh_insert_enable), .ovh_serial_data_in(ovh_serial_data_in));

  task automatic stop_test;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_count(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      mismatches++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic ran_out;
    mismatches++;
    $display("BAD %0t wait ran out", $time);
  endtask

  // Follows one merged frame: slot count, first byte, ones after that byte
  task automatic frame_stream(output int len, output logic [7:0] first, output int rest);
    int n;
    len = 0;
    rest = 0;
    first = 8'h00;
    n = 0;
    @(posedge ovh_clock);
    while (tx_ovh_frame_start !== 1'b1 && n < 400) begin
      @(posedge ovh_clock);
      n++;
    end
    if (n >= 400) begin
      ran_out();
    end
    do begin
      if (tx_ovh_valid === 1'b1) begin
        if (len < 8) begin
          first = {first[6:0], tx_ovh_bit};
        end else begin
          rest += (tx_ovh_bit === 1'b1);
        end
        len++;
      end
      @(posedge ovh_clock);
    end while (tx_ovh_frame_start !== 1'b1 && len < 200);
  endtask

  task automatic set_mode(input logic [1:0] m, input logic [1:0] ovr, input logic ins, input logic ib);
    @(posedge clock);
    cfg_mode <= m;
    cfg_src_override <= ovr;
    ins_on <= ins;
    int_ovh_bit <= ib;
    repeat (40) @(posedge clock);
  endtask

  // Waits for a frame pulse, counts its link cycles and strobe cycles within
  task automatic frame_pulse(output int hi, output int stb, output logic s0);
    int n;
    hi = 0;
    stb = 0;
    n = 0;
    while (ovh_frame_pulse !== 1'b0 && n < 1400) begin
      @(posedge ovh_clock);
      n++;
    end
    while (ovh_frame_pulse !== 1'b1 && n < 1400) begin
      @(posedge ovh_clock);
      n++;
    end
    if (n >= 1400) begin
      ran_out();
    end
    s0 = ovh_byte_slot_strobe;
    while (ovh_frame_pulse === 1'b1 && hi < 40) begin
      hi++;
      stb += (ovh_byte_slot_strobe === 1'b1);
      @(posedge ovh_clock);
    end
    if (hi >= 40) begin
      ran_out();
    end
  endtask

  task automatic next_byte(input int skip, input logic [7:0] exp, input logic ext);
    int n;
    n = 0;
    repeat (skip + 1) @(posedge clock);
    while (ovh_byte_valid !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    if (n >= 400) begin
      ran_out();
    end
    cmp_byte(ovh_byte_out, exp);
    cmp_byte({7'h00, ovh_byte_ext}, {7'h00, ext});
  endtask

  task automatic t_ds3;
    int         hi, stb, len, rest;
    logic       s0;
    logic [7:0] first;
    set_mode(2'h0, 2'h0, 1'b1, 1'b0);
    frame_pulse(hi, stb, s0);
    cmp_count(hi, 2);
    cmp_count(stb, 0);
    next_byte(8, 8'hA5, 1'b1);
    frame_stream(len, first, rest);
    cmp_count(len, `OVH_DS3_FRAME_SLOTS);
    cmp_byte(first, 8'hA5);
    cmp_count(rest, 0);
  endtask

  task automatic t_poh;
    int hi, stb;
    logic s0;
    set_mode(2'h1, 2'h0, 1'b1, 1'b0);
    frame_pulse(hi, stb, s0);
    cmp_count(hi, 16);
    cmp_count(stb, 2);
    cmp_byte({7'h00, s0}, 8'h01);
    next_byte(0, 8'hA5, 1'b1);
  endtask

  task automatic t_gate(input logic [1:0] ovr, input logic ib, input logic [7:0] exp, input logic ext);
    int hi, stb;
    logic s0;
    set_mode(2'h1, ovr, 1'b0, ib);
    frame_pulse(hi, stb, s0);
    next_byte(0, exp, ext);
  endtask

  task automatic t_toh;
    int h1, h2, s1, s2;
    logic a, b;
    set_mode(2'h2, 2'h0, 1'b1, 1'b0);
    frame_pulse(h1, s1, a);
    frame_pulse(h2, s2, b);
    cmp_count(h1 + h2, 4);
    cmp_byte({7'h00, a ^ b}, 8'h01);
  endtask

  task automatic t_toh_ovr;
    int hi, stb;
    logic s0;
    set_mode(2'h2, 2'h2, 1'b0, 1'b1);
    frame_pulse(hi, stb, s0);
    if (s0 !== 1'b0) begin
      frame_pulse(hi, stb, s0);
    end
    cmp_byte({7'h00, s0}, 8'h00);
    cmp_count(hi, 2);
    next_byte(8, 8'hA5, 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_ds3();
    t_poh();
    t_gate(2'h0, 1'b1, 8'hFF, 1'b0);
    t_gate(2'h1, 1'b0, 8'hA5, 1'b1);
    t_toh();
    t_toh_ovr();
    stop_test();
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      stop_test();
    end
  end
endmodule
